//--- hdl/ofd_decoder.sv
// Opcode field decoder top: registers one decode per accepted request
// and offers control and status over APB.
// Assumes requests are synchronous to clk and held only for one cycle.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module ofd_decoder (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire ofd_pkg::ofd_req_t req,
  output ofd_pkg::ofd_dec_t     dec,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr
);
  import ofd_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic        invalid_reg;
  logic [15:0] count_reg;
  logic [15:0] inv_count_reg;
  logic [31:0] imm_next;
  ofd_sreg_t   sreg_next;
  logic        sreg_inv;
  logic        dec_en;
  logic        take;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;
  logic [2:0]  cond_next;

  // Decoding enabled by software control bit
  assign dec_en = ctrl_reg[OFD_CTRL_EN_BIT];
  assign take   = clk_en && dec_en && req.valid;

  // ------------------------------------------------------------
  // Field decode slices
  // ------------------------------------------------------------
  ofd_imm_ext u_imm (
    .sext_bit  (req.sext_bit),
    .imm_width (req.imm_width),
    .dst_width (req.dst_width),
    .imm_raw   (req.imm_raw),
    .imm_ext   (imm_next)
  );

  // is software's duty; the invalid flag covers the case it is broken
  ofd_sreg_sel u_sreg (
    .enable     (req.is_sreg_move),
    .move_class (req.move_class),
    .sreg_sel   (req.sreg_sel),
    .sreg       (sreg_next),
    .invalid    (sreg_inv)
  );

  // Upper three bits name the condition; table order is the code itself
  always_comb begin
    unique case (req.cond_field[3:1])
      3'h0: cond_next = OFD_CC_OVF;
      3'h1: cond_next = OFD_CC_BLW;
      3'h2: cond_next = OFD_CC_EQ;
      3'h3: cond_next = OFD_CC_BE;
      3'h4: cond_next = OFD_CC_SGN;
      3'h5: cond_next = OFD_CC_PAR;
      3'h6: cond_next = OFD_CC_LT;
      3'h7: cond_next = OFD_CC_LE;
    endcase
  end

  // ------------------------------------------------------------
  // Decode output register
  // ------------------------------------------------------------
  // Valid is a one-cycle pulse while clk_en is high and holds while clk_en is low; other fields hold until the next decode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dec <= '{valid: 1'b0, reg_is_src: 1'b0, reg_is_dst: 1'b0, imm_ext: 32'h0000_0000,
               cond_sel: 3'h0, cond_negate: 1'b0, sreg: OFD_SR_NONE, invalid_op: 1'b0};
    end else if (clk_en) begin
      dec.valid <= take;
      if (take) begin
        dec.reg_is_src  <= ~req.dir_bit;
        dec.reg_is_dst  <= req.dir_bit;
        dec.imm_ext     <= imm_next;
        dec.cond_sel    <= cond_next;
        dec.cond_negate <= req.cond_field[OFD_NEG_BIT];
        dec.sreg        <= sreg_next;
        dec.invalid_op  <= sreg_inv;
      end
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign addr_ok = (paddr == OFD_CTRL_OFS) || (paddr == OFD_STATUS_OFS) ||
                   (paddr == OFD_COUNT_OFS) || (paddr == OFD_LAST_OFS);
  // Access phase completes at once since pready is registered high
  assign apb_wr  = psel && penable && pready && pwrite && clk_en;
  assign apb_rd  = psel && !penable && !pwrite && clk_en;

  // Control register; clear bit is self-clearing, never stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= OFD_CTRL_RESET;
    end else if (apb_wr && paddr == OFD_CTRL_OFS) begin
      ctrl_reg <= {31'h0000_0000, pwdata[OFD_CTRL_EN_BIT]};
    end
  end

  // Sticky invalid flag; a new invalid decode wins over a software clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      invalid_reg <= 1'b0;
    end else if (take && sreg_inv) begin
      invalid_reg <= 1'b1;
    end else if (apb_wr && paddr == OFD_CTRL_OFS && pwdata[OFD_CTRL_CLR_BIT]) begin
      invalid_reg <= 1'b0;
    end
  end

  // Counters of decodes and of invalid decodes; wrap silently
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg     <= 16'h0000;
      inv_count_reg <= 16'h0000;
    end else if (apb_wr && paddr == OFD_CTRL_OFS && pwdata[OFD_CTRL_CLR_BIT]) begin
      count_reg     <= 16'h0000;
      inv_count_reg <= 16'h0000;
    end else if (take) begin
      count_reg     <= count_reg + 16'h0001;
      inv_count_reg <= inv_count_reg + {15'h0000, sreg_inv};
    end
  end

  // Ready rises in setup and falls after the access edge: one wait-free access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Read data latched in setup so it stands for the whole access phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      unique case (paddr)
        OFD_CTRL_OFS:   prdata <= ctrl_reg;
        OFD_STATUS_OFS: prdata <= {31'h0000_0000, invalid_reg};
        OFD_COUNT_OFS:  prdata <= {inv_count_reg, count_reg};
        OFD_LAST_OFS:   prdata <= {20'h0_0000, dec.sreg};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : ofd_decoder

//--- hdl/ofd_pkg.sv
// Package for the opcode field decoder: field layouts, codes and decode carriers.
// Assumes the fetch path presents one opcode at a time with its field qualifiers.
package ofd_pkg;

  // ------------------------------------------------------------
  // Register map (APB, byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFD_CTRL_OFS    = 8'h00;
  localparam logic [7:0] OFD_STATUS_OFS  = 8'h04;
  localparam logic [7:0] OFD_COUNT_OFS   = 8'h08;
  localparam logic [7:0] OFD_LAST_OFS    = 8'h0C;
  localparam logic [31:0] OFD_CTRL_RESET = 32'h0000_0001;
  localparam int OFD_CTRL_EN_BIT     = 0;
  localparam int OFD_CTRL_CLR_BIT    = 1;
  localparam int OFD_STAT_INV_BIT    = 0;

  // ------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------
  localparam int OFD_NEG_BIT = 0;               // Low bit of the condition field
  localparam logic [2:0] OFD_CC_OVF  = 3'h0;
  localparam logic [2:0] OFD_CC_BLW  = 3'h1;
  localparam logic [2:0] OFD_CC_EQ   = 3'h2;
  localparam logic [2:0] OFD_CC_BE   = 3'h3;
  localparam logic [2:0] OFD_CC_SGN  = 3'h4;
  localparam logic [2:0] OFD_CC_PAR  = 3'h5;
  localparam logic [2:0] OFD_CC_LT   = 3'h6;
  localparam logic [2:0] OFD_CC_LE   = 3'h7;

  // Special register target, one-hot
  typedef enum logic [11:0] {
    OFD_SR_NONE  = 12'h001,
    OFD_SR_CTL0  = 12'h002,
    OFD_SR_FAULT = 12'h004,
    OFD_SR_PDBR  = 12'h008,
    OFD_SR_BP0   = 12'h010,
    OFD_SR_BP1   = 12'h020,
    OFD_SR_BP2   = 12'h040,
    OFD_SR_BP3   = 12'h080,
    OFD_SR_DSTAT = 12'h100,
    OFD_SR_DCTRL = 12'h200,
    OFD_SR_TCMD  = 12'h400,
    OFD_SR_TDATA = 12'h800
  } ofd_sreg_t;

  // Class of special register move
  typedef enum logic [2:0] {
    OFD_MV_CTRL  = 3'h1,
    OFD_MV_DEBUG = 3'h2,
    OFD_MV_TEST  = 3'h4
  } ofd_move_t;

  // Immediate width codes
  localparam logic [1:0] OFD_W8  = 2'h0;
  localparam logic [1:0] OFD_W16 = 2'h1;
  localparam logic [1:0] OFD_W32 = 2'h2;

  // Request from the fetch path
  typedef struct packed {
    logic        valid;
    logic        dir_bit;
    logic        sext_bit;
    logic [1:0]  imm_width;
    logic [1:0]  dst_width;
    logic [31:0] imm_raw;
    logic [3:0]  cond_field;
    logic        is_sreg_move;
    ofd_move_t   move_class;
    logic [2:0]  sreg_sel;
  } ofd_req_t;

  // Decoded controls
  typedef struct packed {
    logic        valid;
    logic        reg_is_src;
    logic        reg_is_dst;
    logic [31:0] imm_ext;
    logic [2:0]  cond_sel;
    logic        cond_negate;
    ofd_sreg_t   sreg;
    logic        invalid_op;
  } ofd_dec_t;

endpackage : ofd_pkg

//--- hdl/ofd_imm_ext.sv
// Immediate extension slice of the opcode field decoder.
// Assumes widths are given as ofd_pkg width codes; purely combinational.
`timescale 1ns/1ns
module ofd_imm_ext (
  input  wire logic        sext_bit,
  input  wire logic [1:0]  imm_width,
  input  wire logic [1:0]  dst_width,
  input  wire logic [31:0] imm_raw,
  output logic [31:0]      imm_ext
);
  import ofd_pkg::*;

  logic widen;

  // ------------------------------------------------------------
  // Extension
  // ------------------------------------------------------------
  // Sign bit only matters for a byte immediate into a wider target
  assign widen = (imm_width == OFD_W8) && (dst_width != OFD_W8);

  always_comb begin
    if (widen && sext_bit) begin
      imm_ext = {{24{imm_raw[7]}}, imm_raw[7:0]};
    end else if (imm_width == OFD_W8) begin
      imm_ext = {24'h00_0000, imm_raw[7:0]};
    end else begin
      imm_ext = imm_raw;
    end
  end

endmodule : ofd_imm_ext

//--- hdl/ofd_sreg_sel.sv
// Special register selector decode for control, debug and test moves.
// Assumes move_class is one of the three one-hot codes; purely combinational.
`timescale 1ns/1ns
module ofd_sreg_sel (
  input  wire logic              enable,
  input  wire ofd_pkg::ofd_move_t move_class,
  input  wire logic [2:0]        sreg_sel,
  output ofd_pkg::ofd_sreg_t     sreg,
  output logic                   invalid
);
  import ofd_pkg::*;

  // ------------------------------------------------------------
  // Selector table
  // ------------------------------------------------------------
  // Undefined codes map to no register and raise invalid, never a guess
  always_comb begin
    sreg    = OFD_SR_NONE;
    invalid = 1'b0;
    if (enable) begin
      unique case (move_class)
        OFD_MV_CTRL: begin
          case (sreg_sel)
            3'h0:    sreg = OFD_SR_CTL0;
            3'h2:    sreg = OFD_SR_FAULT;
            3'h3:    sreg = OFD_SR_PDBR;
            default: invalid = 1'b1;
          endcase
        end
        OFD_MV_DEBUG: begin
          case (sreg_sel)
            3'h0:    sreg = OFD_SR_BP0;
            3'h1:    sreg = OFD_SR_BP1;
            3'h2:    sreg = OFD_SR_BP2;
            3'h3:    sreg = OFD_SR_BP3;
            3'h6:    sreg = OFD_SR_DSTAT;
            3'h7:    sreg = OFD_SR_DCTRL;
            default: invalid = 1'b1;
          endcase
        end
        OFD_MV_TEST: begin
          case (sreg_sel)
            3'h6:    sreg = OFD_SR_TCMD;
            3'h7:    sreg = OFD_SR_TDATA;
            default: invalid = 1'b1;
          endcase
        end
        default: invalid = 1'b1;                                   // Bad class code
      endcase
    end
  end

endmodule : ofd_sreg_sel

//--- test/ofd_fetch_model.sv
// Fetch-path stand-in that hands opcode requests to the decoder.
// Assumes the bench drives cmd on clock edges; purely combinational.
`timescale 1ns/1ns
module ofd_fetch_model (
  input  wire ofd_pkg::ofd_req_t cmd,
  input  wire logic              allow_bad,
  output ofd_pkg::ofd_req_t      req
);
  import ofd_pkg::*;
  logic ok_code;
  // Selector codes that software may emit for each move class
  always_comb begin
    case (cmd.move_class)
      OFD_MV_CTRL:  ok_code = (cmd.sreg_sel == 3'h0) || (cmd.sreg_sel[2:1] == 2'h1);
      OFD_MV_DEBUG: ok_code = !cmd.sreg_sel[2] || cmd.sreg_sel[1];
      default:      ok_code = cmd.sreg_sel[2:1] == 2'h3;
    endcase
  end
  // Software issues an undefined move only if a test asks for one or a bad class code comes with selector 6 or 7
  always_comb begin
    req = cmd;
    if (cmd.is_sreg_move && !ok_code && !allow_bad)
      req.valid = 1'b0;
  end
endmodule : ofd_fetch_model

//--- test/ofd_decoder_sva.sv
// Checker for the opcode field decoder: ties each decode to its request.
// Assumes it is bound to ofd_decoder and sees only its ports.
`timescale 1ns/1ns
module ofd_decoder_chk (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              clk_en,
  input wire ofd_pkg::ofd_req_t req,
  input wire ofd_pkg::ofd_dec_t dec
);
  import ofd_pkg::*;
  ofd_req_t r_q;
  logic     ce_q;
  logic     hit;
  logic     mv;
  // Request one edge back; a frozen clk_en must not count as a new result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q  <= '0;
      ce_q <= 1'b0;
    end else begin
      r_q  <= req;
      ce_q <= clk_en;
    end
  end
  assign hit = dec.valid && ce_q;
  assign mv  = hit && r_q.is_sreg_move;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_dir_src: assert property (hit |-> dec.reg_is_src == !r_q.dir_bit)
    else $error("register field source wrong");
  a_dir_dst: assert property (hit |-> dec.reg_is_dst == r_q.dir_bit)
    else $error("register field destination wrong");
  a_sext_byte: assert property (hit && r_q.imm_width == OFD_W8 && r_q.dst_width != OFD_W8
    && r_q.sext_bit |-> dec.imm_ext == {{24{r_q.imm_raw[7]}}, r_q.imm_raw[7:0]})
    else $error("byte immediate not sign extended");
  a_wide_pass: assert property (hit && r_q.imm_width != OFD_W8 |-> dec.imm_ext == r_q.imm_raw)
    else $error("wide immediate altered");
  a_cond_neg: assert property (hit |-> dec.cond_negate == r_q.cond_field[0])
    else $error("negate flag wrong");
  a_cond_sel: assert property (hit |-> dec.cond_sel == r_q.cond_field[3:1])
    else $error("condition select wrong");
  a_cond_high: assert property (hit && r_q.cond_field[3] |-> dec.cond_sel[2])
    else $error("upper condition group lost");
  a_ctrl_zero: assert property (mv && r_q.move_class == OFD_MV_CTRL && r_q.sreg_sel == 3'h0
    |-> dec.sreg == OFD_SR_CTL0) else $error("control move target wrong");
  a_dbg_stat: assert property (mv && r_q.move_class == OFD_MV_DEBUG && r_q.sreg_sel == 3'h6
    |-> dec.sreg == OFD_SR_DSTAT) else $error("debug move target wrong");
  a_bad_none: assert property (hit && dec.invalid_op |-> dec.sreg == OFD_SR_NONE && mv)
    else $error("invalid move touched a register");
endmodule : ofd_decoder_chk
bind ofd_decoder ofd_decoder_chk u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .req(req), .dec(dec));

//--- test/testbench.sv
// Self-checking bench for the opcode field decoder.
// Assumes the fetch model feeds req and the bench acts as APB master.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, a); end end
module testbench;
  import ofd_pkg::*;
  logic        clk, reset_n, clk_en, psel, penable, pwrite, allow_bad, pready, pslverr;
  logic        err, en, ce_d;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  ofd_req_t    cmd, req, r;
  ofd_dec_t    dec, e;
  ofd_dec_t    expq[$];
  int          miscompares, n_compared;
  ofd_fetch_model u_fetch (.cmd(cmd), .allow_bad(allow_bad), .req(req));
  ofd_decoder u_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req(req), .dec(dec),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic ofd_sreg_t exp_sreg(input ofd_req_t q);
    logic [2:0] s;
    s = q.sreg_sel;
    if (q.move_class == OFD_MV_CTRL)
      return (s == 3'h0) ? OFD_SR_CTL0 : (s == 3'h2) ? OFD_SR_FAULT :
             (s == 3'h3) ? OFD_SR_PDBR : OFD_SR_NONE;
    if (q.move_class == OFD_MV_DEBUG)
      return (s < 3'h4) ? ofd_sreg_t'(OFD_SR_BP0 << s) : (s == 3'h6) ? OFD_SR_DSTAT :
             (s == 3'h7) ? OFD_SR_DCTRL : OFD_SR_NONE;
    if (q.move_class == OFD_MV_TEST)
      return (s == 3'h6) ? OFD_SR_TCMD : (s == 3'h7) ? OFD_SR_TDATA : OFD_SR_NONE;
    // A move class outside the three known codes reaches no register
    return OFD_SR_NONE;
  endfunction : exp_sreg
  function automatic ofd_dec_t exp_dec(input ofd_req_t q);
    ofd_dec_t d;
    d.valid       = 1'b1;
    d.reg_is_src  = !q.dir_bit;
    d.reg_is_dst  = q.dir_bit;
    d.imm_ext     = q.imm_raw;
    if (q.imm_width == OFD_W8)
      d.imm_ext = (q.sext_bit && q.dst_width != OFD_W8) ? {{24{q.imm_raw[7]}}, q.imm_raw[7:0]}
                  : {24'h000000, q.imm_raw[7:0]};
    d.cond_sel    = q.cond_field[3:1];
    d.cond_negate = q.cond_field[0];
    d.sreg        = q.is_sreg_move ? exp_sreg(q) : OFD_SR_NONE;
    d.invalid_op  = q.is_sreg_move && d.sreg == OFD_SR_NONE;
    return d;
  endfunction : exp_dec
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  // Offer one request and note the decode it must give, if any
  task automatic send(input ofd_req_t q, input logic ab, input logic ce);
    @(posedge clk);
    cmd       <= q;
    allow_bad <= ab;
    clk_en    <= ce;
    if (q.valid && en && ce && (ab || !q.is_sreg_move || exp_sreg(q) != OFD_SR_NONE))
      expq.push_back(exp_dec(q));
  endtask : send
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // Result watcher; a decode held by a low clk_en is not a new one
  always @(posedge clk) begin
    if (reset_n && ce_d && dec.valid === 1'b1) begin
      `CHK("pending", 1'b1, expq.size() != 0)
      if (expq.size() != 0) begin
        e = expq.pop_front();
        `CHK("decode", e, dec)
      end
    end
    ce_d = clk_en;
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, allow_bad, reset_n} = '0;
    cmd = '0;
    clk_en = 1'b1;
    en = 1'b1;
    seed = 32'h15BE;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, OFD_CTRL_OFS, 32'h0);
    `CHK("ctrl", OFD_CTRL_RESET, rd)
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    tdone("registers");
    for (int i = 0; i < 72; i++) begin
      seed = xs(seed);
      r = '0;
      r.valid = 1'b1;
      r.dir_bit = seed[0];
      r.sext_bit = seed[1];
      r.imm_width = seed[3:2] % 2'h3;
      r.dst_width = seed[5:4] % 2'h3;
      r.imm_raw = xs(seed);
      r.cond_field = i[3:0];
      r.is_sreg_move = (i % 24) < 16;
      r.move_class = (i < 24) ? OFD_MV_CTRL : (i < 48) ? OFD_MV_DEBUG : OFD_MV_TEST;
      r.sreg_sel = i[2:0];
      send(r, 1'b1, 1'b1);
    end
    // Unknown move class code must be flagged, not routed
    r.is_sreg_move = 1'b1;
    r.move_class = ofd_move_t'(3'h3);
    send(r, 1'b1, 1'b1);
    send('0, 1'b0, 1'b1);
    tdone("fields");
    apb(1'b0, OFD_STATUS_OFS, 32'h0);
    `CHK("status set", 32'h1, rd)
    apb(1'b1, OFD_CTRL_OFS, 32'h3);
    r.move_class = OFD_MV_CTRL;
    r.is_sreg_move = 1'b1;
    r.sreg_sel = 3'h1;
    send(r, 1'b0, 1'b1);
    r.sreg_sel = 3'h0;
    send(r, 1'b0, 1'b1);
    send('0, 1'b0, 1'b1);
    apb(1'b0, OFD_STATUS_OFS, 32'h0);
    `CHK("status clear", 32'h0, rd)
    apb(1'b0, OFD_COUNT_OFS, 32'h0);
    `CHK("count", 32'h0000_0001, rd)
    apb(1'b0, OFD_LAST_OFS, 32'h0);
    `CHK("last", {20'h0_0000, OFD_SR_CTL0}, rd)
    tdone("illegal");
    apb(1'b1, OFD_CTRL_OFS, 32'h0);
    en = 1'b0;
    send(r, 1'b1, 1'b1);
    send('0, 1'b0, 1'b1);
    apb(1'b1, OFD_CTRL_OFS, 32'h1);
    en = 1'b1;
    send(r, 1'b1, 1'b0);
    send('0, 1'b0, 1'b1);
    send(r, 1'b1, 1'b1);
    send('0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    `CHK("drained", 1'b1, expq.size() == 0)
    tdone("refusals");
    stop_test();
  end
endmodule : testbench
